// ==== verilog/scan_trigger_sequencer.sv ====
// scan trigger sequencer: registers, start modes, trigger handling, channel queue stepping
`timescale 1ns/1ps
`include "scan_seq_params.svh"
module scan_trigger_sequencer
  import scan_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic trigger_in,
  input wire logic ext_timebase_in,
  output logic conv_start,
  output logic [8:0] conv_channel,
  output logic scan_first,
  output logic post_trigger,
  output logic busy
);
  localparam seq_s rst_val = '{state: idle, ctrl: `RST_CTRL, scan_interval: `RST_SCAN_INT,
    sample_interval: `RST_SAMP_INT, scan_count: `RST_SCAN_CNT, spsc: `RST_SPSC,
    queue_len: `RST_QLEN, pre_count: `RST_PRE, delay_count: `RST_DELAY,
    retrig_count: `RST_RETRIG, default: '0};

  seq_s st;
  seq_s next_st;
  pacer_if pif ();
  logic trig_edge;
  logic start;
  logic running;
  logic dtick;
  logic guard_ok;
  logic [23:0] sc_load;
  logic [31:0] wword;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
    input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction

  function automatic mode_e mode_of(input logic [8:0] c);
    mode_e m;
    m = mode_soft;
    unique case (c[`CTRL_MODE_HI:`CTRL_MODE_LO])
      3'h1: m = mode_pre;
      3'h2: m = mode_post;
      3'h3: m = mode_middle;
      3'h4: m = mode_delay;
      default: m = mode_soft;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] reg_word(input seq_s s, input logic [5:0] a);
    logic [31:0] w;
    logic [15:0] kept;
    w = '0;
    kept = (s.pre_done > s.pre_count) ? s.pre_count : s.pre_done;
    unique case (a)
      `OFS_CTRL: w = {23'h000000, s.ctrl};
      `OFS_SCAN_INT: w = {8'h00, s.scan_interval};
      `OFS_SAMP_INT: w = {16'h0000, s.sample_interval};
      `OFS_SCAN_CNT: w = {8'h00, s.scan_count};
      `OFS_SPSC: w = {23'h000000, s.spsc};
      `OFS_QLEN: w = {22'h000000, s.queue_len};
      `OFS_PRE: w = {16'h0000, s.pre_count};
      `OFS_DELAY: w = {16'h0000, s.delay_count};
      `OFS_RETRIG: w = {16'h0000, s.retrig_count};
      `OFS_STATUS: w = {kept, 12'h000, s.stop_pending, s.state};
      `OFS_SERVED: w = {16'h0000, s.served};
      default: w = '0;
    endcase
    return w;
  endfunction

  // pacer scan and sample interval counters only count while a mode is actually converting; the free-running sampling clock always counts
  assign running = (st.state == pre_run) || (st.state == acquire);
  assign pif.run = running;
  assign pif.ext_sel = st.ctrl[`CTRL_EXT_TB];
  assign pif.ext_clock = ext_timebase_in;
  assign pif.scan_interval = st.scan_interval;
  assign pif.sample_interval = st.sample_interval;
  assign pif.samples_per_scan = st.spsc;

  scan_pacer pacer_u (
    .clock(clock),
    .rst_n(rst_n),
    .pif(pif)
  );

  assign trig_edge = st.ctrl[`CTRL_RISE] ? (trigger_in & ~st.trig_prev) : (~trigger_in & st.trig_prev);
  assign start = write && (address == `OFS_CTRL) && byteenable[0] && writedata[`CTRL_START] && (st.state == idle);
  assign dtick = st.ctrl[`CTRL_DLY_SAMP] ? pif.sample_tick : pif.tb_tick;
  assign guard_ok = !st.ctrl[`CTRL_GUARD] || (st.pre_done >= st.pre_count);
  // a zero scan count would run for 2^24 scans, so it is taken as one
  assign sc_load = (st.scan_count == 24'h000000) ? `SCAN_MIN : st.scan_count;
  assign wword = be_merge(reg_word(st, address), writedata, byteenable);

  always_comb
  begin
    next_st = st;
    next_st.trig_prev = trigger_in;
    if (write)
    begin
      unique case (address)
        `OFS_CTRL: next_st.ctrl = {wword[`CTRL_W-1:1], 1'b0};
        `OFS_SCAN_INT: next_st.scan_interval = wword[23:0];
        `OFS_SAMP_INT: next_st.sample_interval = wword[15:0];
        `OFS_SCAN_CNT: next_st.scan_count = wword[23:0];
        `OFS_SPSC: next_st.spsc = wword[8:0];
        `OFS_QLEN: next_st.queue_len = wword[9:0];
        `OFS_PRE: next_st.pre_count = wword[15:0];
        `OFS_DELAY: next_st.delay_count = wword[15:0];
        `OFS_RETRIG: next_st.retrig_count = wword[15:0];
        default: next_st.rd_ack = st.rd_ack;
      endcase
    end
    if (read && !st.rd_ack)
    begin
      next_st.rd_ack = 1'b1;
      next_st.rdata = reg_word(st, address);
    end
    else
      next_st.rd_ack = 1'b0;
    if (pif.conv)
    begin
      if ({1'b0, st.chan} + 10'h001 >= st.queue_len)
        next_st.chan = '0;
      else
        next_st.chan = st.chan + 9'h001;
    end
    unique case (st.state)
      idle:
      begin
        if (start)
        begin
          next_st.chan = '0;
          next_st.pre_done = '0;
          next_st.served = '0;
          next_st.stop_pending = 1'b0;
          next_st.post = 1'b0;
          // mode arrives in the same write as start, so decode the new word
          unique case (mode_of(next_st.ctrl))
            mode_pre, mode_middle: next_st.state = pre_run;
            mode_post, mode_delay: next_st.state = wait_trig;
            default:
            begin
              next_st.state = acquire;
              next_st.scans_left = sc_load;
              next_st.post = 1'b1;
            end
          endcase
        end
      end
      pre_run:
      begin
        if (pif.scan_end && st.pre_done != 16'hFFFF)
          next_st.pre_done = st.pre_done + 16'h0001;
        if (st.stop_pending)
        begin
          if (pif.scan_end)
            next_st.state = idle;
        end
        else if (trig_edge && guard_ok)
        begin
          next_st.served = st.served + 16'h0001;
          if (mode_of(st.ctrl) == mode_pre)
          begin
            if (pif.in_scan)
              next_st.stop_pending = 1'b1;
            else
              next_st.state = idle;
          end
          else
          begin
            // scan in flight stays running and becomes the first post scan
            next_st.state = acquire;
            next_st.scans_left = sc_load;
            next_st.post = 1'b1;
          end
        end
      end
      wait_trig:
      begin
        if (trig_edge)
        begin
          next_st.served = st.served + 16'h0001;
          next_st.post = 1'b1;
          if (mode_of(st.ctrl) == mode_delay)
          begin
            next_st.state = delaying;
            next_st.dly = st.delay_count;
          end
          else
          begin
            next_st.state = acquire;
            next_st.scans_left = sc_load;
          end
        end
      end
      delaying:
      begin
        if (st.dly == 16'h0000)
        begin
          next_st.state = acquire;
          next_st.scans_left = sc_load;
        end
        else if (dtick)
          next_st.dly = st.dly - 16'h0001;
      end
      acquire:
      begin
        // triggers are not looked at here, so a burst is never cut short
        if (pif.scan_end)
        begin
          if (st.scans_left == 24'h000001)
          begin
            if (st.ctrl[`CTRL_RETRIG] && (st.served < st.retrig_count) &&
              (mode_of(st.ctrl) == mode_post || mode_of(st.ctrl) == mode_delay))
              next_st.state = wait_trig;
            else
              next_st.state = idle;
          end
          else
            next_st.scans_left = st.scans_left - 24'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      st <= rst_val;
    else
      st <= next_st;
  end

  assign waitrequest = read && !st.rd_ack;
  assign readdata = st.rdata;
  assign conv_start = pif.conv;
  assign conv_channel = st.chan;
  assign scan_first = pif.scan_begin;
  assign post_trigger = st.post;
  assign busy = (st.state != idle);

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_run_to_idle;
    ((st.state == pre_run) || (st.state == acquire)) ##1 (st.state == idle);
  endsequence
  sequence s_burst_trigger;
    (st.state == acquire) && trig_edge;
  endsequence
  sequence s_guard_blocks;
    (st.state == pre_run) && !st.stop_pending && st.ctrl[`CTRL_GUARD] && (st.pre_done < st.pre_count);
  endsequence

  chk_queue_wrap: assert property (pif.conv && ({1'b0, st.chan} + 10'h001 >= st.queue_len) |=> st.chan == 9'h000)
    else $error("channel did not wrap to first queue entry");
  chk_conv_in_run: assert property (conv_start |-> $past(running))
    else $error("conversion launched outside a running scan");
  chk_edge_pick: assert property (trig_edge |-> (trigger_in == st.ctrl[`CTRL_RISE]) && $changed(trigger_in))
    else $error("trigger edge taken on the wrong polarity");
  chk_soft_start: assert property (start && mode_of(next_st.ctrl) == mode_soft |=> st.state == acquire ##0 busy)
    else $error("software start did not begin acquiring");
  chk_guard_hold: assert property (s_guard_blocks |=> st.state == pre_run)
    else $error("trigger accepted before pre-trigger scans were done");
  chk_whole_scan: assert property (s_run_to_idle |-> !$past(pif.in_scan))
    else $error("acquisition stopped inside a scan");
  chk_delay_zero: assert property ((st.state == delaying) && (st.dly == 16'h0000) |=> st.state == acquire)
    else $error("delay expiry did not start acquisition");
  chk_burst_deaf: assert property (s_burst_trigger |=> $stable(st.served))
    else $error("trigger counted during a burst");
  chk_idle_deaf: assert property ((st.state == idle) && trig_edge && !start |=> st.state == idle ##1 !conv_start)
    else $error("idle sequencer reacted to a trigger");
endmodule

// ==== verilog/scan_seq_params.svh ====
// constants for the scan trigger sequencer: offsets, fields, reset values, timebase
// Behaviour
// - channels step in queue order and wrap to entry zero after the last
// - every scan conversion comes from the interval counters, never from software
// - base clock is the on-board timebase or the external clock input
// - five start modes; all but software act on an external trigger
// - trigger is one edge of the trigger input, rising or falling by choice
// - software mode starts at once and takes samples-per-scan times scan-count
// - pre-trigger converts until the trigger and keeps the last 16-bit count of scans
// - trigger mid-scan in pre-trigger finishes that scan and counts it as retained
// - guard set ignores triggers until the pre-trigger scans are converted
// - acquisition never stops inside a scan, so whole scans are stored
// - middle-trigger keeps pre-trigger scans, then takes scan-count scans after
// - guard acts in middle-trigger exactly as in pre-trigger mode
// - scan in progress at a middle trigger is the first post-trigger scan
// - post-trigger waits for the trigger, then takes scan-count scans
// - delay mode counts a 16-bit delay down after the trigger, then acquires
// - delay counter ticks on the base clock or on the sampling clock
// - with re-trigger in post or delay mode, each served trigger yields scan-count scans
// - triggers during a re-trigger burst are ignored until the burst ends
// - bursts repeat in post and delay modes until the programmed trigger count has been served
`ifndef SCAN_SEQ_PARAMS_SVH
`define SCAN_SEQ_PARAMS_SVH
`define CLK_MHZ 8'h7D
`define TB_INT_MHZ 8'h18
`define OFS_CTRL 6'h00
`define OFS_SCAN_INT 6'h04
`define OFS_SAMP_INT 6'h08
`define OFS_SCAN_CNT 6'h0C
`define OFS_SPSC 6'h10
`define OFS_QLEN 6'h14
`define OFS_PRE 6'h18
`define OFS_DELAY 6'h1C
`define OFS_RETRIG 6'h20
`define OFS_STATUS 6'h24
`define OFS_SERVED 6'h28
`define CTRL_START 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 3
`define CTRL_RISE 4
`define CTRL_GUARD 5
`define CTRL_EXT_TB 6
`define CTRL_DLY_SAMP 7
`define CTRL_RETRIG 8
`define CTRL_W 9
`define RST_CTRL 9'h010
`define RST_SCAN_INT 24'h0003C0
`define RST_SAMP_INT 16'h00F0
`define RST_SCAN_CNT 24'h000001
`define RST_SPSC 9'h001
`define RST_QLEN 10'h001
`define RST_PRE 16'h0001
`define RST_DELAY 16'h0000
`define RST_RETRIG 16'h0001
`define SCAN_MIN 24'h000001
`endif

// ==== verilog/scan_seq_pkg.sv ====
// types shared by the scan trigger sequencer and its pacer
package scan_seq_pkg;
  typedef enum logic [2:0] {mode_soft, mode_pre, mode_post, mode_middle, mode_delay} mode_e;
  typedef enum logic [2:0] {idle, pre_run, wait_trig, delaying, acquire} state_e;
  typedef struct packed {
    logic [7:0] tb_acc;
    logic ext_prev;
    logic tb_tick;
    logic sample_tick;
    logic [15:0] free_cnt;
    logic [23:0] scan_cnt;
    logic [15:0] samp_cnt;
    logic [8:0] left;
    logic in_scan;
    logic conv;
    logic scan_begin;
    logic scan_end;
  } pacer_s;
  typedef struct packed {
    state_e state;
    logic [8:0] ctrl;
    logic [23:0] scan_interval;
    logic [15:0] sample_interval;
    logic [23:0] scan_count;
    logic [8:0] spsc;
    logic [9:0] queue_len;
    logic [15:0] pre_count;
    logic [15:0] delay_count;
    logic [15:0] retrig_count;
    logic trig_prev;
    logic [8:0] chan;
    logic [23:0] scans_left;
    logic [15:0] pre_done;
    logic stop_pending;
    logic [15:0] served;
    logic [15:0] dly;
    logic post;
    logic rd_ack;
    logic [31:0] rdata;
  } seq_s;
endpackage

// ==== verilog/pacer_if.sv ====
// link between the sequencer control and its interval pacer
`timescale 1ns/1ps
interface pacer_if;
  logic run;
  logic ext_sel;
  logic ext_clock;
  logic [23:0] scan_interval;
  logic [15:0] sample_interval;
  logic [8:0] samples_per_scan;
  logic tb_tick;
  logic sample_tick;
  logic conv;
  logic scan_begin;
  logic scan_end;
  logic in_scan;
  modport ctrl (output run, ext_sel, ext_clock, scan_interval, sample_interval, samples_per_scan,
    input tb_tick, sample_tick, conv, scan_begin, scan_end, in_scan);
  modport pacer (input run, ext_sel, ext_clock, scan_interval, sample_interval, samples_per_scan,
    output tb_tick, sample_tick, conv, scan_begin, scan_end, in_scan);
endinterface

// ==== verilog/scan_pacer.sv ====
// timebase selection and scan/sample interval counters
`timescale 1ns/1ps
`include "scan_seq_params.svh"
module scan_pacer
  import scan_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  pacer_if.pacer pif
);
  pacer_s ps;
  pacer_s next_ps;
  logic tick;

  always_comb
  begin
    next_ps = ps;
    tick = 1'b0;
    next_ps.conv = 1'b0;
    next_ps.scan_begin = 1'b0;
    next_ps.scan_end = 1'b0;
    next_ps.sample_tick = 1'b0;
    next_ps.ext_prev = pif.ext_clock;
    // fractional accumulator gives the on-board rate from the system clock
    if (!pif.ext_sel)
    begin
      if (ps.tb_acc >= `CLK_MHZ - `TB_INT_MHZ)
      begin
        next_ps.tb_acc = ps.tb_acc + `TB_INT_MHZ - `CLK_MHZ;
        tick = 1'b1;
      end
      else
        next_ps.tb_acc = ps.tb_acc + `TB_INT_MHZ;
    end
    else
      tick = pif.ext_clock & ~ps.ext_prev;
    next_ps.tb_tick = tick;
    // free-running sampling clock for the delay counter; zero means 65536
    if (tick)
    begin
      if (ps.free_cnt == 16'h0000)
      begin
        next_ps.free_cnt = pif.sample_interval - 16'h0001;
        next_ps.sample_tick = 1'b1;
      end
      else
        next_ps.free_cnt = ps.free_cnt - 16'h0001;
    end
    if (!pif.run)
    begin
      next_ps.scan_cnt = '0;
      next_ps.samp_cnt = '0;
      next_ps.left = '0;
      next_ps.in_scan = 1'b0;
    end
    else if (tick)
    begin
      if (ps.scan_cnt == 24'h000000)
      begin
        next_ps.scan_cnt = pif.scan_interval - 24'h000001;
        next_ps.samp_cnt = pif.sample_interval - 16'h0001;
        next_ps.conv = 1'b1;
        next_ps.scan_begin = 1'b1;
        if (pif.samples_per_scan <= 9'h001)
        begin
          next_ps.scan_end = 1'b1;
          next_ps.in_scan = 1'b0;
        end
        else
        begin
          next_ps.left = pif.samples_per_scan - 9'h001;
          next_ps.in_scan = 1'b1;
        end
      end
      else
      begin
        next_ps.scan_cnt = ps.scan_cnt - 24'h000001;
        if (ps.in_scan)
        begin
          if (ps.samp_cnt == 16'h0000)
          begin
            next_ps.conv = 1'b1;
            next_ps.left = ps.left - 9'h001;
            next_ps.samp_cnt = pif.sample_interval - 16'h0001;
            if (ps.left == 9'h001)
            begin
              next_ps.scan_end = 1'b1;
              next_ps.in_scan = 1'b0;
            end
          end
          else
            next_ps.samp_cnt = ps.samp_cnt - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ps <= '0;
    else
      ps <= next_ps;
  end

  assign pif.tb_tick = ps.tb_tick;
  assign pif.sample_tick = ps.sample_tick;
  // gated by run: a scan launched in the cycle the run stops must not leak out
  assign pif.conv = ps.conv & pif.run;
  assign pif.scan_begin = ps.scan_begin & pif.run;
  assign pif.scan_end = ps.scan_end & pif.run;
  assign pif.in_scan = ps.in_scan;
endmodule

// ==== verification/trigger_source.sv ====
// far-side model: external trigger edges and a gated external timebase
`timescale 1ns/1ps
module trigger_source
(
  input wire logic clock,
  input wire logic fire,
  input wire logic rise,
  input wire logic ext_run,
  output logic trigger_in,
  output logic ext_timebase_in
);
  logic [3:0] phase = 4'h0;
  logic [1:0] div = 2'h0;
  initial trigger_in = 1'b0;
  initial ext_timebase_in = 1'b0;
  // opposite level first, so the chosen edge always lands a fixed time after fire
  always @(posedge clock)
  begin
    if (fire)
      phase <= 4'hC;
    else if (phase != 4'h0)
      phase <= phase - 4'h1;
    if (phase > 4'h8)
      trigger_in <= ~rise;
    else if (phase > 4'h4)
      trigger_in <= rise;
    else if (phase != 4'h0)
      trigger_in <= ~rise;
  end
  // stands still while not running, like a gated external clock
  always @(posedge clock)
  begin
    div <= ext_run ? div + 2'h1 : 2'h0;
    ext_timebase_in <= ext_run & div[1];
  end
endmodule

// ==== verification/scan_trigger_sequencer_tb_top.sv ====
// testbench for the scan trigger sequencer: bus tasks, stream monitor, scenarios
`timescale 1ns/1ps
`include "scan_seq_params.svh"
module scan_trigger_sequencer_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic fire = 1'b0;
  logic rise = 1'b1;
  logic ext_run = 1'b0;
  logic [31:0] readdata;
  logic waitrequest, trigger_in, ext_timebase_in, conv_start, scan_first, post_trigger, busy;
  logic [8:0] conv_channel;
  logic [8:0] exp_ch = 9'h000;
  logic [31:0] rd;
  int num_errors = 0;
  int n_compared = 0;
  int n_conv = 0;
  int n_first = 0;
  always #4 clock = ~clock;
  scan_trigger_sequencer i_scan_trigger_sequencer (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .trigger_in(trigger_in), .ext_timebase_in(ext_timebase_in), .conv_start(conv_start),
    .conv_channel(conv_channel), .scan_first(scan_first), .post_trigger(post_trigger), .busy(busy));
  trigger_source i_trigger_source (.clock(clock), .fire(fire), .rise(rise), .ext_run(ext_run),
    .trigger_in(trigger_in), .ext_timebase_in(ext_timebase_in));
  task automatic end_of_test();
    $display("counts: %0d compared, %0d wrong", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    num_errors++;
    $display("wrong value %s: expected done seen timeout", what);
    end_of_test();
  endtask
  // queue index must follow entry order and wrap; scans open on entry zero
  always @(posedge clock)
    if (conv_start === 1'b1)
    begin
      n_conv++;
      n_first += (scan_first === 1'b1);
      chk("channel", conv_channel, exp_ch);
      chk("scan_first", scan_first, exp_ch == 9'h0);
      exp_ch = (exp_ch >= 9'h2) ? 9'h0 : exp_ch + 9'h1;
    end
  task automatic bus(input logic dir, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= dir;
    read <= ~dir;
    do
    begin
      @(posedge clock);
      if (++k > 50) hang("bus answer");
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wait_conv(input int n);
    int k;
    k = 0;
    while (n_conv < n)
    begin
      settle(1);
      if (++k > 5000) hang("conversions");
    end
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0)
    begin
      settle(1);
      if (++k > 5000) hang("busy to drop");
    end
  endtask
  task automatic pulse(input logic r);
    @(posedge clock);
    rise <= r;
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask
  task automatic start(input logic [31:0] ctrl, input logic [31:0] sc, input logic [31:0] pre,
    input logic [31:0] dly, input logic [31:0] rt);
    bus(1'b1, `OFS_SCAN_INT, 32'h8);
    bus(1'b1, `OFS_SAMP_INT, 32'h2);
    bus(1'b1, `OFS_SCAN_CNT, sc);
    bus(1'b1, `OFS_SPSC, 32'h3);
    bus(1'b1, `OFS_QLEN, 32'h3);
    bus(1'b1, `OFS_PRE, pre);
    bus(1'b1, `OFS_DELAY, dly);
    bus(1'b1, `OFS_RETRIG, rt);
    n_conv = 0;
    n_first = 0;
    bus(1'b1, `OFS_CTRL, ctrl);
  endtask
  task automatic t_reset();
    logic [5:0] ofs [11] = '{`OFS_CTRL, `OFS_SCAN_INT, `OFS_SAMP_INT, `OFS_SCAN_CNT, `OFS_SPSC, `OFS_QLEN,
      `OFS_PRE, `OFS_DELAY, `OFS_RETRIG, `OFS_STATUS, 6'h3C};
    logic [31:0] val [11] = '{`RST_CTRL, `RST_SCAN_INT, `RST_SAMP_INT, `RST_SCAN_CNT, `RST_SPSC, `RST_QLEN,
      `RST_PRE, `RST_DELAY, `RST_RETRIG, 32'h0, 32'h0};
    for (int i = 0; i < 11; i++)
    begin
      bus(1'b0, ofs[i], 32'h0);
      chk("reset value", rd, val[i]);
    end
    chk("busy after reset", busy, 1'b0);
    $display("test reset values done");
  endtask
  task automatic t_soft();
    start(32'h011, 2, 1, 0, 1);
    settle(1);
    chk("busy at start", busy, 1'b1);
    chk("post_trigger soft", post_trigger, 1'b1);
    wait_idle();
    chk("soft samples", n_conv, 6);
    chk("soft scans", n_first, 2);
    pulse(1'b1);
    settle(60);
    chk("trigger after end", n_conv, 6);
    chk("busy after end", busy, 1'b0);
    $display("test software start done");
  endtask
  task automatic t_post();
    start(32'h005, 3, 1, 0, 1);
    settle(200);
    chk("post before trigger", n_conv, 0);
    chk("post_trigger early", post_trigger, 1'b0);
    pulse(1'b0);
    wait_idle();
    chk("post samples", n_conv, 9);
    $display("test post trigger done");
  endtask
  task automatic t_retrig();
    start(32'h115, 2, 1, 0, 2);
    pulse(1'b1);
    wait_conv(2);
    pulse(1'b1);
    wait_conv(6);
    settle(150);
    chk("burst one", n_conv, 6);
    chk("waiting retrigger", busy, 1'b1);
    pulse(1'b1);
    wait_idle();
    chk("retrig total", n_conv, 12);
    bus(1'b0, `OFS_SERVED, 32'h0);
    chk("served", rd, 2);
    $display("test re-trigger done");
  endtask
  task automatic t_delay();
    logic [31:0] ctl [2] = '{32'h019, 32'h099};
    int quiet [2] = '{40, 85};
    for (int i = 0; i < 2; i++)
    begin
      start(ctl[i], 2, 1, 10, 1);
      pulse(1'b1);
      settle(quiet[i]);
      chk("delay quiet", n_conv, 0);
      wait_idle();
      chk("delay samples", n_conv, 6);
    end
    $display("test delay trigger done");
  endtask
  task automatic t_pre();
    logic [31:0] ctl [2] = '{32'h013, 32'h017};
    int exp [2] = '{3, 6};
    start(32'h033, 2, 2, 0, 1);
    pulse(1'b1);
    settle(40);
    chk("guard ignores", busy, 1'b1);
    settle(150);
    pulse(1'b1);
    wait_idle();
    chk("whole scans", n_conv % 3, 0);
    chk("guard scans", n_conv >= 6, 1'b1);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("retained", rd[31:16], 2);
    for (int i = 0; i < 2; i++)
    begin
      start(ctl[i], 2, 1, 0, 1);
      settle(3);
      pulse(1'b1);
      wait_idle();
      chk("mid-scan trigger", n_conv, exp[i]);
    end
    $display("test pre and middle trigger done");
  endtask
  task automatic t_ext();
    start(32'h051, 2, 1, 0, 1);
    settle(100);
    chk("ext clock still", n_conv, 0);
    @(posedge clock);
    ext_run <= 1'b1;
    wait_idle();
    chk("ext samples", n_conv, 6);
    @(posedge clock);
    ext_run <= 1'b0;
    $display("test external timebase done");
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_soft();
    t_post();
    t_retrig();
    t_delay();
    t_pre();
    t_ext();
    end_of_test();
  end
endmodule
